// file: hw/wcpd_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// wait, chip-select and power-down control block.
// Assumes inclusion by bare name from the package and the design.
`ifndef WCPD_CFG_SVH
`define WCPD_CFG_SVH

// ----------------------------------------------------------------
// I/O port addresses
// ----------------------------------------------------------------
`define WCPD_PORT_WDT_MASTER  8'hF3
`define WCPD_PORT_WDT_CMD     8'hF4
`define WCPD_PORT_INDEX       8'hF5
`define WCPD_PORT_DATA        8'hF6
`define WCPD_ONCHIP_NIBBLE    4'hF
`define WCPD_WDT_KEY_HALT_POWER_MODE    8'h4D

// ----------------------------------------------------------------
// Indirect register indexes
// ----------------------------------------------------------------
`define WCPD_IDX_WAIT_CTL     8'h00
`define WCPD_IDX_WAIT_WINDOW  8'h01
`define WCPD_IDX_CS_BOUNDARY  8'h03
`define WCPD_IDX_MISC_CTL     8'h04
`define WCPD_IDX_MAX          8'h0C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WCPD_RST_WAIT_CTL     8'hFF
`define WCPD_RST_WAIT_WINDOW  8'hF0
`define WCPD_RST_CS_BOUNDARY  8'h0F
`define WCPD_RST_MISC_CTL     8'hFF
`define WCPD_RST_HALT_MODE    2'h3
`define WCPD_WDT_RESERVED     3'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WCPD_F_INTACK_HI      7
`define WCPD_F_INTACK_LO      6
`define WCPD_F_VEC_WAIT       5
`define WCPD_F_FETCH_EXT      4
`define WCPD_F_MEM_HI         3
`define WCPD_F_MEM_LO         2
`define WCPD_F_IO_HI          1
`define WCPD_F_IO_LO          0
`define WCPD_F_EOP_EN         0
`define WCPD_F_CS0_EN         1

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define WCPD_BOOT_FETCHES     4'hF

`endif

// file: hw/wcpd_pkg.sv
// Types shared by the wait, chip-select and power-down block.
// Assumes wcpd_cfg.svh is on the include path.
`include "wcpd_cfg.svh"

package wcpd_pkg;

   // ----------------------------------------------------------------
   // Bus cycle kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WCPD_CYC_MEM    = 2'b00,
      WCPD_CYC_IO     = 2'b01,
      WCPD_CYC_FETCH  = 2'b10,
      WCPD_CYC_INTACK = 2'b11
   } wcpd_cyc_e;

   typedef enum logic [1:0] {
      WCPD_WS_IDLE = 2'b00,
      WCPD_WS_T2   = 2'b01,
      WCPD_WS_WAIT = 2'b10
   } wcpd_ws_e;

   typedef enum logic [1:0] {
      WCPD_HM_IDLE_ALL_CLOCKS_OFF = 2'b00,
      WCPD_HM_IDLE_TIMER_KEPT = 2'b01,
      WCPD_HM_STOP  = 2'b10,
      WCPD_HM_RUN   = 2'b11
   } wcpd_hm_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        start;
      wcpd_cyc_e   kind;
      logic [15:0] addr;
   } wcpd_bus_s;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wcpd_io_s;

   typedef struct packed {
      logic osc;
      logic system_clock_output;
      logic core;
      logic parallel;
      logic serial;
      logic timer;
      logic watchdog;
   } wcpd_clk_s;

   typedef struct packed {
      logic [7:0] wait_ctl;
      logic [7:0] wait_window;
      logic [7:0] cs_boundary;
      logic [7:0] misc_ctl;
      logic [7:0] index;
      wcpd_hm_e   halt_mode;
      logic       key_armed;
      logic [3:0] fetch_cnt;
      logic       boot_done;
      logic       sw_wrote;
      logic       m1_prev_n;
      wcpd_ws_e   ws;
      logic [2:0] wait_cnt;
      logic [2:0] wait_len;
      logic       halted;
      logic       cs0_n;
      logic       cs1_n;
      logic       eop;
      logic [7:0] rdata;
   } wcpd_state_s;

endpackage : wcpd_pkg

// file: hw/wcpd_ctl.sv
// Wait-state generator, memory wait window, two chip selects and
// halt power-down clock gating, with indirect register access.
// Assumes core bus cycle and I/O strobes synchronous to clk.
//
// Function
// RQ1: Vector wait bit adds one wait in interrupt acknowledge cycles.
// RQ2: Fetch extension bit adds one wait to every opcode fetch.
// RQ3: Memory wait field gives 0 to 3 waits on memory cycles.
// RQ4: I/O wait field gives 0 to 3 waits on external I/O.
// RQ5: On-chip I/O accesses always take zero waits.
// RQ6: Wait bits start all ones, clear after sixteenth fetch unless written.
// RQ7: Memory waits only apply inside the programmed wait window.
// RQ8: Upper select when address nibble above low and within high boundary.
// RQ9: Low select when nibble within low boundary and its enable set.
// RQ10: Chip select boundary resets to 0F.
// RQ11: Misc control register read/write, enables high after reset.
// RQ12: Halt status goes low at fourth T-state of halt fetch.
// RQ13: Core runs no-operation cycles while halted with clock running.
// RQ14: Run mode halting stops no clock.
// RQ15: First idle mode stops clock output and all unit clocks.
// RQ16: Second idle mode keeps timer and clock output running.
// RQ17: Stop mode halts oscillator, clock output and all clocks.
// RQ18: Halt mode field 00 idle_all_clocks_off, 01 idle_timer_kept, 10 stop, 11 run.
// RQ19: Software writes index port, then uses the data port.
// RQ20: Each wait stretches the cycle one clock between T2 and T3.
`timescale 1ns/1ps
`include "wcpd_cfg.svh"

module wcpd_ctl (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Core bus cycles
   input  wire wcpd_pkg::wcpd_bus_s bus,
   input  wire logic             io_request_strobe_n,
   input  wire logic             opcode_fetch_cycle_strobe_n,
   output logic                  wait_active,
   // Register port
   input  wire wcpd_pkg::wcpd_io_s io,
   output logic [7:0]            io_rdata,
   // Chip selects and misc outputs
   output logic                  low_region_select_n,
   output logic                  upper_region_select_n,
   input  wire logic             end_of_program_req,
   output logic                  end_of_program_output,
   output logic [7:0]            output_enables,
   // Halt
   input  wire logic             halt_t4,
   input  wire logic             halt_wake,
   output logic                  halt_status_n,
   output logic                  core_nop,
   // Clock gating
   output wcpd_pkg::wcpd_clk_s   clk_run,
   output logic [1:0]            halt_power_mode
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] wait_count(
      input logic [7:0]  wctl,
      input logic [7:0]  win,
      input wcpd_pkg::wcpd_bus_s b);
      logic [3:0] nib;
      logic       in_win;
      logic [2:0] mem;
      nib    = b.addr[15:12];
      in_win = (nib >= win[3:0]) && (nib <= win[7:4]);
      mem    = in_win ? {1'b0, wctl[`WCPD_F_MEM_HI:`WCPD_F_MEM_LO]} : 3'h0; // see RQ3, RQ7
      case (b.kind)
         wcpd_pkg::WCPD_CYC_MEM:    wait_count = mem; // see RQ3
         wcpd_pkg::WCPD_CYC_FETCH:  wait_count = mem + {2'h0, wctl[`WCPD_F_FETCH_EXT]}; // see RQ2
         wcpd_pkg::WCPD_CYC_IO:
            if (b.addr[7:4] == `WCPD_ONCHIP_NIBBLE)
               wait_count = 3'h0; // see RQ5
            else
               wait_count = {1'b0, wctl[`WCPD_F_IO_HI:`WCPD_F_IO_LO]}; // see RQ4
         wcpd_pkg::WCPD_CYC_INTACK:
            wait_count = {wctl[`WCPD_F_INTACK_HI:`WCPD_F_INTACK_LO], 1'b0}
                       + {2'h0, wctl[`WCPD_F_VEC_WAIT]}; // see RQ1
         default:                   wait_count = 3'h0;
      endcase
   endfunction : wait_count

   function automatic logic port_hit(input wcpd_pkg::wcpd_io_s p, input logic [7:0] a);
      port_hit = (p.addr == a);
   endfunction : port_hit

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   wcpd_pkg::wcpd_state_s st_r;
   wcpd_pkg::wcpd_state_s st_nxt;
   logic [3:0]            nib;
   logic                  m1_trail;
   logic                  data_wr;

   assign nib      = bus.addr[15:12];
   assign m1_trail = !st_r.m1_prev_n && opcode_fetch_cycle_strobe_n;
   assign data_wr  = io.wr && port_hit(io, `WCPD_PORT_DATA);

   always_comb begin
      st_nxt           = st_r;
      st_nxt.m1_prev_n = opcode_fetch_cycle_strobe_n;

      // ----------------------------------------------------------------
      // Boot-time slow wait settings
      // ----------------------------------------------------------------
      if (m1_trail && !st_r.boot_done) begin
         if (st_r.fetch_cnt == `WCPD_BOOT_FETCHES) begin
            st_nxt.boot_done = 1'b1;
            if (!st_r.sw_wrote && !(data_wr && st_r.index == `WCPD_IDX_WAIT_CTL))
               st_nxt.wait_ctl = 8'h00; // see RQ6
         end else begin
            st_nxt.fetch_cnt = st_r.fetch_cnt + 4'h1; // see RQ6
         end
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (io.wr) begin
         if (port_hit(io, `WCPD_PORT_INDEX) && io.wdata <= `WCPD_IDX_MAX)
            st_nxt.index = io.wdata; // see RQ19
         if (port_hit(io, `WCPD_PORT_WDT_CMD))
            st_nxt.key_armed = (io.wdata == `WCPD_WDT_KEY_HALT_POWER_MODE);
         if (port_hit(io, `WCPD_PORT_WDT_MASTER)) begin
            // Mode change needs the command key first, like the watchdog
            if (st_r.key_armed)
               st_nxt.halt_mode = wcpd_pkg::wcpd_hm_e'(io.wdata[4:3]); // see RQ18
            st_nxt.key_armed = 1'b0;
         end
         if (data_wr) begin
            case (st_r.index)
               `WCPD_IDX_WAIT_CTL: begin
                  st_nxt.wait_ctl = io.wdata;
                  st_nxt.sw_wrote = 1'b1; // see RQ6
               end
               `WCPD_IDX_WAIT_WINDOW: st_nxt.wait_window = io.wdata;
               `WCPD_IDX_CS_BOUNDARY: st_nxt.cs_boundary = io.wdata;
               `WCPD_IDX_MISC_CTL:    st_nxt.misc_ctl    = io.wdata; // see RQ11
               default:               st_nxt.misc_ctl    = st_r.misc_ctl;
            endcase
         end
      end

      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      if (io.rd) begin
         if (port_hit(io, `WCPD_PORT_INDEX))
            st_nxt.rdata = st_r.index;
         else if (port_hit(io, `WCPD_PORT_WDT_MASTER))
            st_nxt.rdata = {3'h0, st_r.halt_mode, `WCPD_WDT_RESERVED};
         else if (port_hit(io, `WCPD_PORT_DATA)) begin
            case (st_r.index)
               `WCPD_IDX_WAIT_CTL:    st_nxt.rdata = st_r.wait_ctl;
               `WCPD_IDX_WAIT_WINDOW: st_nxt.rdata = st_r.wait_window;
               `WCPD_IDX_CS_BOUNDARY: st_nxt.rdata = st_r.cs_boundary;
               `WCPD_IDX_MISC_CTL:    st_nxt.rdata = st_r.misc_ctl; // see RQ11
               default:               st_nxt.rdata = 8'h00;
            endcase
         end else
            st_nxt.rdata = 8'h00;
      end

      // ----------------------------------------------------------------
      // Wait-state sequencer
      // ----------------------------------------------------------------
      // Cycle count is latched at T1 so a register write mid-cycle cannot
      // change the length of a cycle already under way.
      case (st_r.ws)
         wcpd_pkg::WCPD_WS_IDLE: begin
            if (bus.start) begin
               st_nxt.ws       = wcpd_pkg::WCPD_WS_T2;
               st_nxt.wait_len = wait_count(st_r.wait_ctl, st_r.wait_window, bus);
            end
         end
         wcpd_pkg::WCPD_WS_T2: begin
            if (st_r.wait_len == 3'h0)
               st_nxt.ws = wcpd_pkg::WCPD_WS_IDLE;
            else begin
               st_nxt.ws       = wcpd_pkg::WCPD_WS_WAIT; // see RQ20
               st_nxt.wait_cnt = st_r.wait_len;
            end
         end
         wcpd_pkg::WCPD_WS_WAIT: begin
            st_nxt.wait_cnt = st_r.wait_cnt - 3'h1; // see RQ20
            if (st_r.wait_cnt == 3'h1)
               st_nxt.ws = wcpd_pkg::WCPD_WS_IDLE;
         end
         default: st_nxt.ws = wcpd_pkg::WCPD_WS_IDLE;
      endcase

      // ----------------------------------------------------------------
      // Chip selects
      // ----------------------------------------------------------------
      st_nxt.cs0_n = !(st_r.misc_ctl[`WCPD_F_CS0_EN]
                       && nib <= st_r.cs_boundary[3:0]); // see RQ9
      st_nxt.cs1_n = !(nib > st_r.cs_boundary[3:0]
                       && nib <= st_r.cs_boundary[7:4]); // see RQ8

      // ----------------------------------------------------------------
      // End of program output
      // ----------------------------------------------------------------
      st_nxt.eop   = end_of_program_req && st_r.misc_ctl[`WCPD_F_EOP_EN]; // see RQ11

      // ----------------------------------------------------------------
      // Halt
      // ----------------------------------------------------------------
      if (halt_t4)
         st_nxt.halted = 1'b1; // see RQ12
      else if (halt_wake)
         st_nxt.halted = 1'b0;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r.wait_ctl    <= `WCPD_RST_WAIT_CTL; // see RQ6
         st_r.wait_window <= `WCPD_RST_WAIT_WINDOW;
         st_r.cs_boundary <= `WCPD_RST_CS_BOUNDARY; // see RQ10
         st_r.misc_ctl    <= `WCPD_RST_MISC_CTL; // see RQ11
         st_r.index       <= 8'h00;
         st_r.halt_mode   <= wcpd_pkg::wcpd_hm_e'(`WCPD_RST_HALT_MODE); // see RQ18
         st_r.key_armed   <= 1'b0;
         st_r.fetch_cnt   <= 4'h0;
         st_r.boot_done   <= 1'b0;
         st_r.sw_wrote    <= 1'b0;
         st_r.m1_prev_n   <= 1'b1;
         st_r.ws          <= wcpd_pkg::WCPD_WS_IDLE;
         st_r.wait_cnt    <= 3'h0;
         st_r.wait_len    <= 3'h0;
         st_r.halted      <= 1'b0;
         st_r.cs0_n       <= 1'b1;
         st_r.cs1_n       <= 1'b1;
         st_r.eop         <= 1'b0;
         st_r.rdata       <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wait_active           = (st_r.ws == wcpd_pkg::WCPD_WS_WAIT); // see RQ20
   assign io_rdata              = st_r.rdata;
   assign low_region_select_n   = st_r.cs0_n;
   assign upper_region_select_n = st_r.cs1_n;
   assign end_of_program_output = st_r.eop;
   assign output_enables        = st_r.misc_ctl;
   assign halt_status_n         = !st_r.halted; // see RQ12
   assign halt_power_mode       = st_r.halt_mode;

   // ----------------------------------------------------------------
   // Clock gating
   // ----------------------------------------------------------------
   // Gate enables are levels; the clock generator stops each at its low phase.
   always_comb begin
      clk_run = '1; // see RQ14
      if (st_r.halted) begin
         case (st_r.halt_mode)
            wcpd_pkg::WCPD_HM_IDLE_ALL_CLOCKS_OFF: begin
               clk_run.osc      = 1'b1; // see RQ15
               clk_run.system_clock_output   = 1'b0;
               clk_run.core     = 1'b0;
               clk_run.parallel = 1'b0;
               clk_run.serial   = 1'b0;
               clk_run.timer    = 1'b0;
               clk_run.watchdog = 1'b0;
            end
            wcpd_pkg::WCPD_HM_IDLE_TIMER_KEPT: begin
               clk_run.osc      = 1'b1; // see RQ16
               clk_run.system_clock_output   = 1'b1;
               clk_run.core     = 1'b0;
               clk_run.parallel = 1'b0;
               clk_run.serial   = 1'b0;
               clk_run.timer    = 1'b1;
               clk_run.watchdog = 1'b0;
            end
            wcpd_pkg::WCPD_HM_STOP: begin
               clk_run.osc      = 1'b0; // see RQ17
               clk_run.system_clock_output   = 1'b0;
               clk_run.core     = 1'b0;
               clk_run.parallel = 1'b0;
               clk_run.serial   = 1'b0;
               clk_run.timer    = 1'b0;
               clk_run.watchdog = 1'b0;
            end
            default:                clk_run = '1; // see RQ14
         endcase
      end
   end

   assign core_nop = st_r.halted && clk_run.core; // see RQ13

   // ----------------------------------------------------------------
   // Unused inputs
   // ----------------------------------------------------------------
   // io_request_strobe_n is carried for timing reference; acknowledge cycles are
   // flagged through bus.kind, and their waits are counted from bus.start.
   logic unused_ok;
   assign unused_ok = io_request_strobe_n;

endmodule : wcpd_ctl

// file: verification/wcpd_ctl_props.sv
// Port checker for the wait, chip-select and halt control block.
// Assumes register writes only arrive through the io port.
`timescale 1ns/1ps
module wcpd_ctl_props (
   input wire logic                clk,
   input wire logic                nrst,
   input wire wcpd_pkg::wcpd_io_s  io,
   input wire wcpd_pkg::wcpd_bus_s bus,
   input wire logic                end_of_program_req,
   input wire logic                end_of_program_output,
   input wire logic [7:0]          output_enables,
   input wire logic                low_region_select_n,
   input wire logic                upper_region_select_n,
   input wire logic                halt_t4,
   input wire logic                halt_status_n,
   input wire logic                core_nop,
   input wire wcpd_pkg::wcpd_clk_s clk_run,
   input wire logic [1:0]          halt_power_mode
);
   logic [7:0] idx_r;
   logic [7:0] csb_r;
   logic [7:0] mcr_r;
   // Shadows, since only misc_ctl reaches a port directly, as output_enables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx_r <= 8'h00;
         csb_r <= 8'h0F;
         mcr_r <= 8'hFF;
      end else if (io.wr && io.addr == 8'hF5 && io.wdata <= 8'h0C) begin
         idx_r <= io.wdata;
      end else if (io.wr && io.addr == 8'hF6 && idx_r == 8'h03) begin
         csb_r <= io.wdata;
      end else if (io.wr && io.addr == 8'hF6 && idx_r == 8'h04) begin
         mcr_r <= io.wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_halt_in; halt_t4 ##1 !halt_status_n; endsequence
   property p_halt_low; halt_t4 |-> s_halt_in; endproperty
   property p_idle_all_clocks_off; !halt_status_n && halt_power_mode == 2'b00 |-> clk_run == 7'h40; endproperty
   property p_idle_timer_kept; !halt_status_n && halt_power_mode == 2'b01 |-> clk_run == 7'h62; endproperty
   property p_stop; !halt_status_n && halt_power_mode == 2'b10 |-> clk_run == 7'h00; endproperty
   property p_run; halt_power_mode == 2'b11 || halt_status_n |-> clk_run == 7'h7F; endproperty
   property p_nop; core_nop == (!halt_status_n && halt_power_mode == 2'b11); endproperty
   property p_low; $past(nrst) |-> low_region_select_n ==
      !($past(bus.addr[15:12]) <= $past(csb_r[3:0]) && $past(mcr_r[1])); endproperty
   property p_up; $past(nrst) |-> upper_region_select_n ==
      !($past(bus.addr[15:12]) > $past(csb_r[3:0]) && $past(bus.addr[15:12]) <= $past(csb_r[7:4])); endproperty
   property p_eop; $past(nrst) |-> end_of_program_output == $past(end_of_program_req && mcr_r[0]); endproperty
   property p_oe; output_enables == mcr_r; endproperty
   a_halt_low: assert property (p_halt_low) else $error("halt status late");
   a_idle_all_clocks_off: assert property (p_idle_all_clocks_off) else $error("idle_all_clocks_off clocks wrong");
   a_idle_timer_kept: assert property (p_idle_timer_kept) else $error("idle_timer_kept clocks wrong");
   a_stop: assert property (p_stop) else $error("stop clocks wrong");
   a_run: assert property (p_run) else $error("run clocks wrong");
   a_nop: assert property (p_nop) else $error("nop state wrong");
   a_low: assert property (p_low) else $error("low select wrong");
   a_up: assert property (p_up) else $error("upper select wrong");
   a_eop: assert property (p_eop) else $error("end of program wrong");
   a_oe: assert property (p_oe) else $error("output enables wrong");
endmodule : wcpd_ctl_props
bind wcpd_ctl wcpd_ctl_props u_props (.*);

// file: verification/wcpd_core_model.sv
// Core bus cycle model facing the block.
// Assumes the bench calls its tasks from negedge-timed code.
`timescale 1ns/1ps
module wcpd_core_model (
   input wire logic            clk,
   input wire logic            wait_active,
   output wcpd_pkg::wcpd_bus_s bus,
   output logic                io_request_strobe_n,
   output logic                opcode_fetch_cycle_strobe_n
);
   initial begin
      bus = '0;
      io_request_strobe_n = 1'b1;
      opcode_fetch_cycle_strobe_n = 1'b1;
   end
   task automatic put(input logic [15:0] a);
      @(negedge clk) bus.addr <= a;
   endtask : put
   // Wide window so any offset of the waits is counted
   task automatic cycle(input logic [1:0] k, input logic [15:0] a, output logic [7:0] n);
      n = 8'h00;
      @(negedge clk) bus <= {1'b1, k, a};
      io_request_strobe_n <= !k[0];
      opcode_fetch_cycle_strobe_n <= (k != 2'b10);
      @(negedge clk) bus.start <= 1'b0;
      repeat (10) begin
         @(negedge clk) n = n + {7'h00, wait_active};
      end
      // Released address must not keep the last value
      bus.addr <= ~a;
      io_request_strobe_n <= 1'b1;
      opcode_fetch_cycle_strobe_n <= 1'b1;
   endtask : cycle
endmodule : wcpd_core_model

// file: verification/tb_top.sv
// Self-checking bench for the wait, chip-select and halt block.
// Assumes the core model drives all bus cycle inputs.
`timescale 1ns/1ps
module tb_top;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   wcpd_pkg::wcpd_bus_s bus;
   wcpd_pkg::wcpd_io_s  io = '0;
   logic                ios_n, fet_n, wact, low_n, up_n, eop, hs_n, nop;
   logic                eop_req = 1'b0, t4 = 1'b0, wake = 1'b0;
   logic [7:0]          rdat, oe, v, n;
   wcpd_pkg::wcpd_clk_s crun;
   logic [1:0]          hpm;
   int                  err_total = 0, n_compared = 0;
   logic [31:0] rows [16] = '{32'h04050001, 32'h08050002, 32'h0C050003, 32'h0C010000, 32'h0C080000,
      32'h00050000, 32'h18230003, 32'h18290001, 32'h01100101, 32'h02100102, 32'h03100103,
      32'h00100100, 32'h03100F50, 32'h20300001, 32'h00300000, 32'hE0300007};
   logic [7:0]  clk_exp [4] = '{8'h40, 8'h62, 8'h00, 8'h7F};
   always #20 clk = ~clk;
   wcpd_core_model core (.clk(clk), .wait_active(wact), .bus(bus), .io_request_strobe_n(ios_n),
      .opcode_fetch_cycle_strobe_n(fet_n));
   wcpd_ctl DUT (.clk(clk), .nrst(nrst), .bus(bus), .io_request_strobe_n(ios_n),
      .opcode_fetch_cycle_strobe_n(fet_n), .wait_active(wact), .io(io), .io_rdata(rdat),
      .low_region_select_n(low_n), .upper_region_select_n(up_n), .end_of_program_req(eop_req),
      .end_of_program_output(eop), .output_enables(oe), .halt_t4(t4), .halt_wake(wake),
      .halt_status_n(hs_n), .core_nop(nop), .clk_run(crun), .halt_power_mode(hpm));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) io <= {1'b0, 1'b1, a, d};
      @(negedge clk) io <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk) io <= {1'b1, 1'b0, a, 8'h00};
      @(negedge clk) io <= '0;
      @(negedge clk) d = rdat;
   endtask : rd
   task automatic rr(input logic [7:0] i, output logic [7:0] d);
      wr(8'hF5, i);
      rd(8'hF6, d);
   endtask : rr
   task automatic rw(input logic [7:0] i, input logic [7:0] d);
      wr(8'hF5, i);
      wr(8'hF6, d);
   endtask : rw
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   initial begin
      #1000000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (15) core.cycle(2'b10, 16'h0000, n);
      chk(n, 8'h04);
      rr(8'h00, v); chk(v, 8'hFF);
      core.cycle(2'b10, 16'h0000, n);
      rr(8'h00, v); chk(v, 8'h00);
      rr(8'h01, v); chk(v, 8'hF0);
      rr(8'h03, v); chk(v, 8'h0F);
      rr(8'h04, v); chk(v, 8'hFF);
      chk({6'h00, hpm}, 8'h03);
      rw(8'h01, 8'h73);
      foreach (rows[i]) begin
         rw(8'h00, rows[i][31:24]);
         core.cycle(rows[i][21:20], rows[i][19:4], n);
         chk(n, {4'h0, rows[i][3:0]});
      end
      // Out-of-range index must leave the pointer alone
      rw(8'h03, 8'h94);
      wr(8'hF5, 8'h20);
      rd(8'hF5, v); chk(v, 8'h03);
      rd(8'hF6, v); chk(v, 8'h94);
      rr(8'h0A, v); chk(v, 8'h00);
      for (int e = 0; e < 2; e++) begin
         rw(8'h04, {6'h00, e[0], 1'b1});
         for (int i = 0; i < 16; i++) begin
            core.put({i[3:0], 12'h000});
            @(negedge clk);
            chk({6'h00, low_n, up_n}, {6'h00, !(i <= 4 && e == 1), !(i > 4 && i <= 9)});
         end
      end
      @(negedge clk) eop_req <= 1'b1;
      @(negedge clk);
      chk({7'h00, eop}, 8'h01);
      rw(8'h04, 8'h02);
      @(negedge clk);
      chk({7'h00, eop}, 8'h00);
      chk(oe, 8'h02);
      wr(8'hF3, 8'h03);
      chk({6'h00, hpm}, 8'h03);
      // Any other command write disarms the key
      wr(8'hF4, 8'h4D);
      wr(8'hF4, 8'h4E);
      wr(8'hF3, 8'h0B);
      chk({6'h00, hpm}, 8'h03);
      for (int m = 0; m < 4; m++) begin
         wr(8'hF4, 8'h4D);
         wr(8'hF3, {3'h0, m[1:0], 3'h3});
         rd(8'hF3, v); chk(v, {3'h0, m[1:0], 3'h3});
         @(negedge clk) t4 <= 1'b1;
         @(negedge clk) t4 <= 1'b0;
         chk({7'h00, hs_n}, 8'h00);
         chk({1'b0, crun}, clk_exp[m]);
         chk({7'h00, nop}, {7'h00, m == 3});
         @(negedge clk) wake <= 1'b1;
         @(negedge clk) wake <= 1'b0;
         chk({7'h00, hs_n}, 8'h01);
      end
      // Mid-run reset; a boot-time write must survive the sixteenth fetch
      @(negedge clk) nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      chk({6'h00, hpm}, 8'h03);
      rr(8'h03, v); chk(v, 8'h0F);
      rw(8'h00, 8'h55);
      repeat (16) core.cycle(2'b10, 16'h0000, n);
      chk(n, 8'h02);
      rr(8'h00, v); chk(v, 8'h55);
      stop_test();
   end
endmodule : tb_top
